//--- verilog/dec_core.v
`include "dec_defines.vh"

module dec_core (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Register port behind the bus target controller
  input wire [`DEC_ADDR_W-1:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  output reg reg_ack,
  // Encoder inputs of counter one
  input wire enc1_a,
  input wire enc1_b,
  input wire enc1_z,
  // Encoder inputs of counter two
  input wire enc2_a,
  input wire enc2_b,
  input wire enc2_z,
  // Reference encoder inputs
  input wire ref_a,
  input wire ref_b,
  input wire ref_z,
  // Digital inputs, active high
  input wire [3:0] din,
  // Reference counter value
  output reg [`DEC_REF_W-1:0] ref_count
);

  // Returns {step, up} from previous and present {A, B} levels.
  function [1:0] quad_step;
    input [1:0] prev;
    input [1:0] cur;
    input [1:0] mode;
    reg a_rise;
    reg a_chg;
    reg b_chg;
    begin
      a_rise = cur[1] & ~prev[1];
      a_chg = cur[1] ^ prev[1];
      b_chg = cur[0] ^ prev[0];
      case (mode)
        `DEC_DEC_X1: quad_step = {a_rise, ~cur[0]};
        `DEC_DEC_X2: quad_step = {a_chg, cur[1] ^ cur[0]};
        `DEC_DEC_X4:
          quad_step = {a_chg ^ b_chg, a_chg ? (cur[1] ^ cur[0]) :
                       ~(cur[1] ^ cur[0])};
        `DEC_DEC_EVT: quad_step = {a_rise, 1'b1};
        default: quad_step = 2'h0;
      endcase
    end
  endfunction

  localparam NIN = 13;

  reg [31:0] mode_reg;
  // Pins are asynchronous: s1 feeds only s2, edges compare s2 with s3.
  reg [NIN-1:0] pin_s1;
  reg [NIN-1:0] pin_s2;
  reg [NIN-1:0] pin_s3;
  reg tb_half;
  reg ref_seen_index;
  reg [`DEC_REF_TW-1:0] ref_tdiv;
  reg ref_evt;
  reg rd_pend;
  reg [`DEC_ADDR_W-1:0] rd_addr;
  reg [1:0] rd_popped;
  wire [NIN-1:0] pin_raw;
  wire din0_edge;
  wire [1:0] ref_st;
  wire ref_step;
  wire ref_up;
  wire ref_clr;
  wire ref_en;
  wire [1:0] fifo_nempty;
  wire [1:0] fifo_ovf;
  wire [1:0] fifo_pop;
  wire [2*`DEC_CNT_W-1:0] fifo_dout;
  wire [31:0] status;

  assign pin_raw = {din, ref_z, ref_b, ref_a,
                    enc2_z, enc2_b, enc2_a, enc1_z, enc1_b, enc1_a};

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_s1 <= {NIN{1'b0}};
      pin_s2 <= {NIN{1'b0}};
      pin_s3 <= {NIN{1'b0}};
      tb_half <= 1'b0;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      tb_half <= ~tb_half;
    end
  end

  // Inputs are active high, so a rising edge is the asserting edge.
  assign din0_edge = mode_reg[`DEC_B_DIN_EDGE] ?
                     (pin_s3[9] & ~pin_s2[9]) :
                     (pin_s2[9] & ~pin_s3[9]);

  // Register writes; the mode register steers every counter.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      mode_reg <= `DEC_MODE_RST;
    end
    else if (reg_wr && reg_addr == `DEC_OFS_MODE)
    begin
      mode_reg <= reg_wdata;
    end
  end

  // Reference counter: incremental encoder or periodic timer.
  assign ref_st = quad_step({pin_s3[6], pin_s3[7]}, {pin_s2[6], pin_s2[7]},
                            mode_reg[`DEC_F_RDEC+1:`DEC_F_RDEC]);
  assign ref_en = mode_reg[`DEC_B_REN];
  assign ref_step = ref_st[1] & ref_en;
  assign ref_up = ref_st[0] ^ mode_reg[`DEC_B_RDIR];
  assign ref_clr = pin_s2[8] ^ mode_reg[`DEC_B_RPOL];

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      ref_count <= {`DEC_REF_W{1'b0}};
      ref_seen_index <= 1'b0;
      ref_tdiv <= {`DEC_REF_TW{1'b0}};
      ref_evt <= 1'b0;
    end
    else if (mode_reg[`DEC_B_RTMR])
    begin
      ref_seen_index <= 1'b0;
      ref_evt <= 1'b0;
      if (ref_en)
      begin
        if (ref_tdiv == `DEC_REF_TICKS - 1)
        begin
          ref_tdiv <= {`DEC_REF_TW{1'b0}};
          ref_count <= ref_count + 1'b1;
          ref_evt <= 1'b1;
        end
        else
        begin
          ref_tdiv <= ref_tdiv + 1'b1;
        end
      end
    end
    else
    begin
      ref_tdiv <= {`DEC_REF_TW{1'b0}};
      ref_evt <= ref_step & ref_seen_index;
      if (ref_clr)
      begin
        ref_count <= {`DEC_REF_W{1'b0}};
        ref_seen_index <= 1'b1;
      end
      else if (ref_step)
      begin
        ref_count <= ref_up ? ref_count + 1'b1 : ref_count - 1'b1;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : ch
      localparam B = gi * `DEC_CH_STRIDE;
      reg [`DEC_CNT_W-1:0] cnt;
      reg last_up;
      reg ovf;
      wire [1:0] st;
      wire en;
      wire step;
      wire up;
      wire idx_clr;
      wire tmode;
      wire tb_tick;
      wire preset;
      wire soft_latch;
      reg trig;
      wire fire;
      wire in_ready;

      assign en = mode_reg[B+`DEC_F_EN];
      assign st = quad_step({pin_s3[3*gi], pin_s3[3*gi+1]},
                            {pin_s2[3*gi], pin_s2[3*gi+1]},
                            mode_reg[B+`DEC_F_DEC+1:B+`DEC_F_DEC]);
      assign step = st[1] & en;
      assign up = st[0] ^ mode_reg[B+`DEC_F_DIR];
      assign idx_clr = pin_s2[3*gi+2] ^ mode_reg[B+`DEC_F_POL];
      assign tmode = mode_reg[B+`DEC_F_TM+1];
      assign tb_tick = mode_reg[B+`DEC_F_TM] | tb_half;
      assign preset = reg_wr && reg_addr == (gi ? `DEC_OFS_CNT2 :
                                             `DEC_OFS_CNT1);
      assign soft_latch = reg_wr && reg_addr == `DEC_OFS_STAT &&
                          reg_wdata[gi];

      always @*
      begin
        case (mode_reg[B+`DEC_F_TRG+1:B+`DEC_F_TRG])
          `DEC_TRG_SOFT: trig = 1'b0;
          `DEC_TRG_DIR: trig = step & (up != last_up);
          `DEC_TRG_REF: trig = ref_evt;
          `DEC_TRG_DIN: trig = din0_edge;
          default: trig = 1'b0;
        endcase
      end

      // Time mode captures the interval on every evaluated edge.
      assign fire = soft_latch | (tmode ? step : trig);

      always @(posedge clk)
      begin
        if (sys_rst)
        begin
          cnt <= {`DEC_CNT_W{1'b0}};
          last_up <= 1'b1;
        end
        else
        begin
          if (step)
          begin
            last_up <= up;
          end
          // Preset is taken even while running; software stops first.
          if (preset)
          begin
            cnt <= reg_wdata;
          end
          else if (idx_clr || (ref_evt && mode_reg[B+`DEC_F_RRST]))
          begin
            cnt <= {`DEC_CNT_W{1'b0}};
          end
          else if (tmode)
          begin
            if (step)
            begin
              // The tick of the step edge opens the next interval.
              cnt <= {{(`DEC_CNT_W-1){1'b0}}, tb_tick};
            end
            else if (en && tb_tick)
            begin
              cnt <= cnt + 1'b1;
            end
          end
          else if (step)
          begin
            cnt <= up ? cnt + 1'b1 : cnt - 1'b1;
          end
        end
      end

      // A capture refused by a full FIFO is lost and flagged; set wins.
      // The flag clears on the edge that samples status, so the read sees it.
      always @(posedge clk)
      begin
        if (sys_rst)
        begin
          ovf <= 1'b0;
        end
        else if (fire && !in_ready)
        begin
          ovf <= 1'b1;
        end
        else if (rd_pend && rd_addr == `DEC_OFS_STAT)
        begin
          ovf <= 1'b0;
        end
      end

      assign fifo_ovf[gi] = ovf;
      assign fifo_pop[gi] = reg_rd &&
                            reg_addr == (gi ? `DEC_OFS_CNT2 : `DEC_OFS_CNT1);

      dec_fifo #(
        .W(`DEC_CNT_W),
        .D(`DEC_FIFO_D),
        .AW(`DEC_FIFO_AW)
      ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(fire),
        .in_ready(in_ready),
        .in_data(cnt),
        .out_valid(fifo_nempty[gi]),
        .out_ready(fifo_pop[gi]),
        .out_data(fifo_dout[gi*`DEC_CNT_W +: `DEC_CNT_W])
      );

      assign status[B+`DEC_S_NEMPTY:B] = {fifo_nempty[gi], ~en, en, 1'b0};
      assign status[B+`DEC_S_OVF] = ovf;
      assign status[B+`DEC_CH_STRIDE-1:B+`DEC_S_OVF+1] = 7'h00;
    end
  endgenerate

  assign status[25:24] = 2'h0;
  assign status[26] = 1'b0;
  assign status[`DEC_S_RRUN] = ref_en;
  assign status[`DEC_S_RSTOP] = ~ref_en;
  assign status[31:29] = 3'h0;

  // Reads answer two cycles after the strobe: the FIFO head is registered.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      rd_pend <= 1'b0;
      rd_addr <= {`DEC_ADDR_W{1'b0}};
      rd_popped <= 2'h0;
      reg_rdata <= 32'h0000_0000;
      reg_ack <= 1'b0;
    end
    else
    begin
      rd_pend <= reg_rd;
      rd_addr <= reg_addr;
      rd_popped <= fifo_pop & fifo_nempty;
      reg_ack <= rd_pend | reg_wr;
      if (rd_pend)
      begin
        case (rd_addr)
          `DEC_OFS_CNT1:
            reg_rdata <= rd_popped[0] ? fifo_dout[31:0] :
                         32'h0000_0000;
          `DEC_OFS_CNT2:
            reg_rdata <= rd_popped[1] ? fifo_dout[63:32] :
                         32'h0000_0000;
          `DEC_OFS_MODE: reg_rdata <= mode_reg;
          `DEC_OFS_STAT: reg_rdata <= status;
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // dec_core

//--- pkg/dec_defines.vh
`ifndef DEC_DEFINES_VH
`define DEC_DEFINES_VH

// Register byte offsets.
`define DEC_OFS_CNT1 5'h00
`define DEC_OFS_CNT2 5'h04
`define DEC_OFS_MODE 5'h08
`define DEC_OFS_STAT 5'h0C
`define DEC_ADDR_W 5

// Main counter field layout, relative to the channel base.
`define DEC_CH_STRIDE 12
`define DEC_F_DEC 0
`define DEC_F_TRG 2
`define DEC_F_TM 4
`define DEC_F_DIR 6
`define DEC_F_POL 7
`define DEC_F_EN 8
`define DEC_F_RRST 9

// Common and reference counter bits of the mode register.
`define DEC_B_DIN_EDGE 22
`define DEC_F_RDEC 26
`define DEC_B_RDIR 28
`define DEC_B_RPOL 29
`define DEC_B_RTMR 30
`define DEC_B_REN 31
`define DEC_MODE_RST 32'h0000_0000

// Status register layout; channel bits relative to the channel base, reference bits absolute.
`define DEC_S_RUN 1
`define DEC_S_STOP 2
`define DEC_S_NEMPTY 3
`define DEC_S_OVF 4
`define DEC_S_RRUN 27
`define DEC_S_RSTOP 28

// Decoding and trigger encodings.
`define DEC_DEC_X1 2'h0
`define DEC_DEC_X2 2'h1
`define DEC_DEC_X4 2'h2
`define DEC_DEC_EVT 2'h3
`define DEC_TRG_SOFT 2'h0
`define DEC_TRG_DIR 2'h1
`define DEC_TRG_REF 2'h2
`define DEC_TRG_DIN 2'h3

// Widths and depths.
`define DEC_CNT_W 32
`define DEC_REF_W 16
`define DEC_FIFO_D 32
`define DEC_FIFO_AW 5

// Timing: clock, slow timebase and fastest reference timer rate in Hz.
`define DEC_CLK_HZ 10000000
`define DEC_TB_SLOW_HZ 5000000
`define DEC_REF_MAX_HZ 20000
`define DEC_TB_DIV (`DEC_CLK_HZ / `DEC_TB_SLOW_HZ)
`define DEC_REF_TICKS (`DEC_CLK_HZ / `DEC_REF_MAX_HZ)
`define DEC_REF_TW 9

`endif

//--- verilog/dec_fifo.v
module dec_fifo #(
  parameter W = 32,
  parameter D = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // Drain side; out_data is registered and updates after a pop
  output wire out_valid,
  input wire out_ready,
  output reg [W-1:0] out_data
);

  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wptr;
  reg [AW-1:0] rptr;
  reg [AW:0] fill;
  wire push;
  wire pop;

  assign in_ready = (fill != D[AW:0]);
  assign out_valid = (fill != {(AW+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk)
  begin
    if (push)
    begin
      mem[wptr] <= in_data;
    end
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      wptr <= {AW{1'b0}};
      rptr <= {AW{1'b0}};
      fill <= {(AW+1){1'b0}};
      out_data <= {W{1'b0}};
    end
    else
    begin
      if (push)
      begin
        wptr <= wptr + 1'b1;
      end
      if (pop)
      begin
        rptr <= rptr + 1'b1;
        out_data <= mem[rptr];
      end
      fill <= fill + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

endmodule // dec_fifo

//--- tb/dec_checker.sv
module dec_checker (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Register port
  input wire [4:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  input wire reg_ack,
  // Reference count
  input wire [15:0] ref_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mode;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // A shadow of the mode word lets stop rules be judged from the pins.
  always @(posedge clk)
  begin
    if (sys_rst)
      mode <= 32'h0;
    else if (reg_wr && reg_addr == 5'h08)
      mode <= reg_wdata;
  end
  sequence rd_at(logic [4:0] a);
    reg_rd && reg_addr == a;
  endsequence
  wr_ack_a:
    assert property (reg_wr |=> reg_ack) else $error("write not acked");
  rd_ack_a:
    assert property (reg_rd |-> ##2 reg_ack) else $error("read not acked");
  ack_cause_a:
    assert property (reg_ack |-> $past(reg_wr) || $past(reg_rd, 2))
    else $error("ack without request");
  mode_rd_a:
    assert property (rd_at(5'h08) |-> ##2 reg_rdata == $past(mode, 2))
    else $error("mode readback wrong");
  unmapped_rd_a:
    assert property (rd_at(5'h10) |-> ##2 reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a:
    assert property (!reg_ack |-> $stable(reg_rdata))
    else $error("read data moved");
  ref_stop_a:
    assert property (!$past(mode[31]) && !$past(sys_rst)
      |-> $stable(ref_count)) else $error("stopped ref moved");
  ref_step_a:
    assert property ($changed(ref_count) && !$past(sys_rst)
      |-> ref_count - $past(ref_count) inside {16'h0001, 16'hFFFF})
    else $error("ref jumped");
endmodule // dec_checker

bind dec_core dec_checker u_chk (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
  .ref_count(ref_count));

//--- tb/dec_enc_model.sv
module dec_enc_model (
  // Clock
  input wire clk,
  // Encoder lines
  output logic a,
  output logic b,
  output logic z
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph = 2'h0;
  initial z = 1'b0;
  // Gray order keeps B a quarter period behind A when stepping up.
  assign a = ph[1] ^ ph[0];
  assign b = ph[1];
  task automatic step(input logic up, input int gap);
    @(negedge clk);
    ph <= up ? ph + 2'h1 : ph - 2'h1;
    repeat (gap) @(negedge clk);
  endtask
  task automatic index(input int len);
    @(negedge clk);
    z <= 1'b1;
    repeat (len) @(negedge clk);
    z <= 1'b0;
  endtask
endmodule // dec_enc_model

//--- tb/tb_dual_encoder_counter_mode_core.sv
module tb_dual_encoder_counter_mode_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic sys_rst;
  logic [4:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic reg_ack;
  logic [3:0] din;
  logic [15:0] ref_count;
  wire [8:0] e;
  logic [31:0] rv;
  int fails;
  int compares;
  dec_enc_model u_e1 (.clk(clk), .a(e[0]), .b(e[1]), .z(e[2]));
  dec_enc_model u_e2 (.clk(clk), .a(e[3]), .b(e[4]), .z(e[5]));
  dec_enc_model u_er (.clk(clk), .a(e[6]), .b(e[7]), .z(e[8]));
  dec_core u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .enc1_a(e[0]),
    .enc1_b(e[1]), .enc1_z(e[2]), .enc2_a(e[3]), .enc2_b(e[4]),
    .enc2_z(e[5]), .ref_a(e[6]), .ref_b(e[7]), .ref_z(e[8]),
    .din(din), .ref_count(ref_count));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] d);
    int n;
    @(negedge clk);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    n = 0;
    while (reg_ack !== 1'b1 && n < 4)
    begin
      @(negedge clk);
      n++;
    end
    rv = reg_rdata;
    chk({31'h0, reg_ack}, 32'h1);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(rv, x);
  endtask
  task automatic latch_check(input logic [4:0] a, input logic [31:0] x);
    bus(1'b1, 5'h0C, a == 5'h04 ? 32'h2 : 32'h1);
    rdc(a, x);
  endtask
  task automatic t_reset();
    rdc(5'h08, 32'h0);
    rdc(5'h00, 32'h0);
    bus(1'b1, 5'h10, 32'hFFFF_FFFF);
    rdc(5'h10, 32'h0);
    rdc(5'h08, 32'h0);
    bus(1'b1, 5'h08, 32'h585A_A1A5);
    rdc(5'h08, 32'h585A_A1A5);
    bus(1'b1, 5'h08, 32'h0);
  endtask
  task automatic t_dec();
    logic [31:0] cnt [4] = '{32'h1, 32'h2, 32'h4, 32'h1};
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 5'h00, 32'h0);
      bus(1'b1, 5'h08, 32'h100 | i);
      repeat (4) u_e1.step(1'b1, 3);
      bus(1'b1, 5'h08, 32'h0);
      latch_check(5'h00, cnt[i]);
    end
  endtask
  task automatic t_dir();
    bus(1'b1, 5'h00, 32'h2);
    rdc(5'h00, 32'h0);
    bus(1'b1, 5'h08, 32'h142);
    repeat (4) u_e1.step(1'b1, 3);
    bus(1'b1, 5'h08, 32'h0);
    latch_check(5'h00, 32'hFFFF_FFFE);
    bus(1'b1, 5'h00, 32'h5);
    repeat (4) u_e1.step(1'b1, 3);
    latch_check(5'h00, 32'h5);
  endtask
  task automatic t_index();
    bus(1'b1, 5'h00, 32'h7);
    bus(1'b1, 5'h08, 32'h180);
    bus(1'b1, 5'h08, 32'h0);
    latch_check(5'h00, 32'h0);
    bus(1'b1, 5'h00, 32'h7);
    bus(1'b1, 5'h08, 32'h100);
    latch_check(5'h00, 32'h7);
    u_e1.index(3);
    latch_check(5'h00, 32'h0);
    bus(1'b1, 5'h08, 32'h0);
  endtask
  task automatic t_din();
    for (int k = 0; k < 2; k++)
    begin
      bus(1'b1, 5'h08, 32'h0);
      bus(1'b1, 5'h04, 32'h9);
      bus(1'b1, 5'h08, 32'h0010_E000 | (k << 22));
      @(negedge clk);
      din = 4'h1;
      repeat (6) @(negedge clk);
      din = 4'h0;
      repeat (6) @(negedge clk);
      rdc(5'h04, 32'h9);
      rdc(5'h04, 32'h0);
    end
    bus(1'b1, 5'h08, 32'h0);
  endtask
  task automatic t_fifo();
    bus(1'b1, 5'h00, 32'h3);
    repeat (33) bus(1'b1, 5'h0C, 32'h1);
    bus(1'b0, 5'h0C, 32'h0);
    chk(rv & 32'h18, 32'h18);
    repeat (32) rdc(5'h00, 32'h3);
    rdc(5'h00, 32'h0);
    bus(1'b0, 5'h0C, 32'h0);
    chk(rv & 32'h18, 32'h0);
  endtask
  task automatic t_time();
    for (int k = 0; k < 2; k++)
    begin
      bus(1'b1, 5'h00, 32'h0);
      bus(1'b1, 5'h08, 32'h122 | (k << 4));
      repeat (4) u_e1.step(1'b1, 3);
      bus(1'b1, 5'h08, 32'h0);
      // The first capture spans the time since start and is dropped.
      bus(1'b0, 5'h00, 32'h0);
      repeat (3) rdc(5'h00, k ? 32'h4 : 32'h2);
      rdc(5'h00, 32'h0);
    end
  endtask
  task automatic t_turn();
    bus(1'b1, 5'h00, 32'h0);
    bus(1'b1, 5'h08, 32'h106);
    repeat (2) u_e1.step(1'b1, 3);
    repeat (2) u_e1.step(1'b0, 3);
    bus(1'b1, 5'h08, 32'h0);
    rdc(5'h00, 32'h2);
    rdc(5'h00, 32'h0);
  endtask
  task automatic t_rinc();
    bus(1'b1, 5'h00, 32'h11);
    bus(1'b1, 5'h08, 32'h8800_0008);
    u_er.step(1'b1, 3);
    chk({16'h0, ref_count}, 32'h1);
    u_er.index(3);
    chk({16'h0, ref_count}, 32'h0);
    repeat (2) u_er.step(1'b1, 3);
    chk({16'h0, ref_count}, 32'h2);
    bus(1'b1, 5'h08, 32'h9800_0008);
    u_er.step(1'b1, 3);
    chk({16'h0, ref_count}, 32'h1);
    bus(1'b1, 5'h08, 32'h0);
    repeat (3) rdc(5'h00, 32'h11);
    rdc(5'h00, 32'h0);
  endtask
  task automatic t_ref();
    logic [15:0] v;
    int n;
    bus(1'b1, 5'h00, 32'h4);
    bus(1'b1, 5'h04, 32'h6);
    bus(1'b1, 5'h08, 32'hC030_0008);
    // The first wait only finds the timer phase; the second is timed.
    for (int j = 0; j < 2; j++)
    begin
      v = ref_count;
      n = 0;
      while (ref_count === v && n < 1200)
      begin
        @(negedge clk);
        n++;
      end
    end
    chk(n, 32'h1F4);
    bus(1'b1, 5'h08, 32'h0);
    latch_check(5'h04, 32'h0);
    rdc(5'h00, 32'h4);
    v = ref_count;
    repeat (600) @(negedge clk);
    chk({16'h0, ref_count}, {16'h0, v});
  endtask
  task automatic final_report();
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #2000000;
    fails++;
    final_report();
  end
  initial
  begin
    sys_rst = 1'b1;
    reg_addr = 5'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h0;
    din = 4'h0;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_dec();
    t_dir();
    t_index();
    t_din();
    t_fifo();
    t_time();
    t_turn();
    t_rinc();
    t_ref();
    final_report();
  end
endmodule // tb_dual_encoder_counter_mode_core
